// >>> shared/ptp_regs.svh
/*
 * register offsets, field positions, reset values and timing counts
 * of the pulse train positioning block; definitions only.
 */
`ifndef PTP_REGS_SVH
`define PTP_REGS_SVH

`define PTP_CTRL_OFS   8'h00
`define PTP_MODE_OFS   5'h00
`define PTP_TGT_OFS    5'h04
`define PTP_PER_OFS    5'h08
`define PTP_CMD_OFS    5'h0c
`define PTP_ELO_OFS    5'h10
`define PTP_EHI_OFS    5'h14
`define PTP_STAT_OFS   5'h18

`define PTP_CW_CLR     0
`define PTP_CW_STOP    3
`define PTP_CW_NEAR    4
`define PTP_CH0_CODE   4'h0
`define PTP_CH1_CODE   4'h2

`define PTP_CMD_JDIR   4
`define PTP_CMD_JTEN   5
`define PTP_CMD_JHOLD  8

`define PTP_CTRL_RST   16'h0000
`define PTP_MODE_RST   8'h00
`define PTP_PER_RST    16'h0032

`define PTP_CLK_NS     10
`define PTP_TICK_NS    100
`define PTP_DEVCLR_NS  1000
`define PTP_TICK_CYC   (`PTP_TICK_NS / `PTP_CLK_NS)
`define PTP_DEVCLR_CYC (`PTP_DEVCLR_NS / `PTP_CLK_NS)

`endif

// >>> shared/ptp_pkg.sv
/*
 * types of the pulse train positioning block.
 * assumes the offsets and counts come from ptp_regs.svh.
 */
package ptp_pkg;

    typedef enum logic [1:0] {
        OP_NONE = 2'b00,
        OP_MOVE = 2'b01,
        OP_HOME = 2'b10,
        OP_JOG  = 2'b11
    } ptp_op_e;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_SETUP = 2'b01,
        ST_RUN   = 2'b10
    } ptp_state_e;

    typedef struct packed {
        ptp_state_e  st;
        ptp_op_e     op;
        logic [1:0]  meth;
        logic        dir;
        logic        lvl;
        logic        decel;
        logic        jten;
        logic        nq;
        logic        a;
        logic        b;
        logic        dc;
        logic [15:0] per;
        logic [15:0] cnt;
        logic [31:0] tgt;
        logic [31:0] remain;
        logic [31:0] elapsed;
        logic [7:0]  dcnt;
    } ptp_chan_s;

    typedef struct packed {
        logic [15:0]      ctrl;
        logic [1:0][7:0]  mode;
        logic [1:0][31:0] target;
        logic [1:0][15:0] period;
        logic [1:0][2:0]  cflag;
        ptp_chan_s [1:0]  ch;
        logic             pready;
        logic             pslverr;
        logic [31:0]      prdata;
    } ptp_top_s;

    typedef struct packed {
        logic [3:0] m;
        logic [3:0] q;
    } ptp_sync_s;

    typedef struct packed {
        logic [7:0] cnt;
        logic       tick;
    } ptp_tick_s;

endpackage : ptp_pkg

// >>> shared/ptp_pin_if.sv
/*
 * pin bundle between the top and its input synchroniser.
 * assumes raw pins are asynchronous to pclk.
 */
`timescale 1ns/1ps
interface ptp_pin_if;
    logic [3:0] raw;
    logic [3:0] sync;
    modport syn (input raw, output sync);
    modport usr (output raw, input sync);
endinterface : ptp_pin_if

// >>> verilog/ptp_sync.sv
/*
 * two-flop synchroniser for the home and near-home pins.
 * assumes pins may change at any time relative to pclk.
 */
`timescale 1ns/1ps
module ptp_sync (
    // clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // pins
    ptp_pin_if.syn    pins
);
    import ptp_pkg::*;

    ptp_sync_s s;
    ptp_sync_s next_s;

    always_comb begin
        next_s   = s;
        next_s.m = pins.raw;
        next_s.q = s.m;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign pins.sync = s.q;
endmodule : ptp_sync

// >>> verilog/ptp_tick.sv
/*
 * divider making the one-cycle rate enable for pulse timing.
 * assumes pclk at the rate set in ptp_regs.svh.
 */
`timescale 1ns/1ps
`include "ptp_regs.svh"
module ptp_tick (
    // clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // rate enable
    output logic      tick
);
    import ptp_pkg::*;

    ptp_tick_s s;
    ptp_tick_s next_s;

    always_comb begin
        next_s      = s;
        next_s.tick = 1'b0;
        if (s.cnt == 8'(`PTP_TICK_CYC - 1)) begin
            next_s.cnt  = 8'h00;
            next_s.tick = 1'b1;
        end else begin
            next_s.cnt = s.cnt + 8'h01;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign tick = s.tick;
endmodule : ptp_tick

// >>> verilog/ptp_top.sv
/*
 * two-channel pulse train positioning output with apb registers.
 * assumes an external pulse-input motor driver on the pins and
 * software that writes the control word as a persistent level.
 */
// The implementer's own choices: the register offsets and register access over APB.

// Behaviour
// - cw/ccw drives separate forward and reverse pulses
// - polarity A: direction low forward, high reverse
// - polarity B: direction high forward, low reverse
// - incremental emits exactly |target| pulses
// - incremental sign picks direction and count sense
// - absolute emits target minus elapsed pulses
// - absolute direction from target versus position
// - home return pulses until home input active
// - near-home bit pulse starts home deceleration
// - deviation clear output after home completes
// - jog pulses while trigger held, stops released
// - jog stops at target match if enabled
// - jog direction from jog command, rate from period register
// - two channels, each pulse plus direction
// - home input fixed, near-home source free
// - control word: reset, stop, near-home
// - control word holds until next write
// - stop code halts pulses at once
// - elapsed value split into two halves
// - elapsed cleared when home return completes
// - mode codes 00,02,03,10,12,13 decoded
`timescale 1ns/1ps
`include "ptp_regs.svh"
module ptp_top (
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // sensor pins
    input  wire logic        home_input_first_channel,
    input  wire logic        home_input_second_channel,
    input  wire logic        near_home_source_first,
    input  wire logic        near_home_source_second,
    // driver pins
    output logic      [1:0]  pulse_a,
    output logic      [1:0]  pulse_b,
    output logic      [1:0]  dev_clr
);
    import ptp_pkg::*;

    ptp_top_s    s;
    ptp_top_s    next_s;
    ptp_chan_s   c;
    logic [31:0] rd;
    logic [31:0] diff;
    logic        hit;
    logic        ci;
    logic        chhit;
    logic        wr;
    logic        start;
    logic        tick;
    logic [1:0]  home_s;
    logic [1:0]  near_src;
    logic [1:0]  clr_c;
    logic [1:0]  stop_c;
    logic [1:0]  near_c;
    logic [1:0]  sel_c;

    ptp_pin_if pins ();

    // home pins are fixed per channel
    assign pins.raw = {near_home_source_second, near_home_source_first,
                       home_input_second_channel, home_input_first_channel};
    assign home_s   = pins.sync[1:0];
    assign near_src = pins.sync[3:2];

    ptp_sync u_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .pins    (pins)
    );

    ptp_tick u_tick (
        .pclk    (pclk),
        .presetn (presetn),
        .tick    (tick)
    );

    // control word stays in force as a level until rewritten
    assign sel_c[0] = s.ctrl[15:12] == `PTP_CH0_CODE;
    assign sel_c[1] = s.ctrl[15:12] == `PTP_CH1_CODE;

    assign chhit = !paddr[7] && (paddr[6] ^ paddr[5]) && (paddr[1:0] == 2'b00);
    assign ci    = paddr[6];
    assign wr    = psel && penable && s.pready && pwrite && !s.pslverr;

    always_comb begin
        next_s = s;
        c      = '0;
        diff   = '0;
        rd     = '0;
        hit    = 1'b0;
        start  = 1'b0;
        if (paddr == `PTP_CTRL_OFS) begin
            hit = 1'b1;
            rd  = {16'h0000, s.ctrl};
        end else if (chhit) begin
            hit = 1'b1;
            case (paddr[4:0])
                `PTP_MODE_OFS: rd = {24'h000000, s.mode[ci]};
                `PTP_TGT_OFS:  rd = s.target[ci];
                `PTP_PER_OFS:  rd = {16'h0000, s.period[ci]};
                `PTP_CMD_OFS:  rd = {23'h000000, s.cflag[ci][2], 2'b00,
                                     s.cflag[ci][1:0], 4'h0};
                // 32-bit position seen as two 16-bit halves
                `PTP_ELO_OFS:  rd = {16'h0000, s.ch[ci].elapsed[15:0]};
                `PTP_EHI_OFS:  rd = {16'h0000, s.ch[ci].elapsed[31:16]};
                `PTP_STAT_OFS: rd = {27'h0000000, near_src[ci], home_s[ci],
                                     s.ch[ci].decel, s.ch[ci].dir,
                                     s.ch[ci].st != ST_IDLE};
                default:       hit = 1'b0;
            endcase
        end

        // answer in the first access cycle, data held from setup
        next_s.pready = 1'b0;
        if (psel && !penable) begin
            next_s.pready  = 1'b1;
            next_s.pslverr = !hit;
            next_s.prdata  = hit ? rd : 32'h00000000;
        end

        if (wr) begin
            if (paddr == `PTP_CTRL_OFS) begin
                next_s.ctrl = pwdata[15:0];
            end else begin
                case (paddr[4:0])
                    `PTP_MODE_OFS: next_s.mode[ci]   = pwdata[7:0];
                    `PTP_TGT_OFS:  next_s.target[ci] = pwdata;
                    `PTP_PER_OFS:  next_s.period[ci] = pwdata[15:0];
                    `PTP_CMD_OFS:  next_s.cflag[ci]  = {pwdata[`PTP_CMD_JHOLD],
                                                        pwdata[`PTP_CMD_JTEN],
                                                        pwdata[`PTP_CMD_JDIR]};
                    default:       next_s.ctrl = s.ctrl;
                endcase
            end
        end

        for (int i = 0; i < 2; i++) begin
            c     = s.ch[i];
            start = wr && chhit && (ci == 1'(i)) && (paddr[4:0] == `PTP_CMD_OFS)
                    && (pwdata[1:0] != OP_NONE);
            if (clr_c[i]) begin
                c.elapsed = 32'h00000000;
            end
            c.nq = near_c[i];
            if (c.dcnt != 8'h00) begin
                c.dcnt = c.dcnt - 8'h01;
            end
            case (c.st)
                ST_IDLE: begin
                    // only an idle channel accepts a command
                    // unlisted mode codes are refused
                    if (start && !stop_c[i] && s.mode[i][3:2] == 2'b00
                        && s.mode[i][7:5] == 3'b000 && s.mode[i][1:0] != 2'b01) begin
                        c.op    = ptp_op_e'(pwdata[1:0]);
                        c.meth  = s.mode[i][1:0];
                        c.tgt   = s.target[i];
                        c.per   = s.period[i];
                        c.cnt   = s.period[i];
                        c.jten  = pwdata[`PTP_CMD_JTEN];
                        c.decel = 1'b0;
                        c.lvl   = 1'b0;
                        // relative or absolute distance
                        diff    = s.mode[i][4] ? s.target[i] - c.elapsed : s.target[i];
                        // sign of distance picks direction
                        // jog and home take the command's direction
                        c.dir    = (c.op == OP_MOVE) ? diff[31] : pwdata[`PTP_CMD_JDIR];
                        c.remain = diff[31] ? 32'h00000000 - diff : diff;
                        if (!(c.op == OP_MOVE && diff == 32'h00000000)
                            && !(c.op == OP_JOG && c.jten && c.elapsed == c.tgt)) begin
                            c.st = ST_SETUP;
                        end
                    end
                end
                ST_SETUP: begin
                    // direction stands one half period before the first edge
                    if (tick) begin
                        if (c.cnt <= 16'h0001) begin
                            c.cnt = c.per;
                            c.lvl = 1'b1;
                            c.st  = ST_RUN;
                        end else begin
                            c.cnt = c.cnt - 16'h0001;
                        end
                    end
                end
                ST_RUN: begin
                    if (c.op == OP_HOME && home_s[i]) begin
                        // home reached: stop, zero, clear pulse
                        c.st      = ST_IDLE;
                        c.lvl     = 1'b0;
                        c.elapsed = 32'h00000000;
                        c.dcnt    = 8'(`PTP_DEVCLR_CYC);
                    end else if (tick) begin
                        if (c.cnt > 16'h0001) begin
                            c.cnt = c.cnt - 16'h0001;
                        end else begin
                            // slow creep by four after the near-home trigger
                            c.cnt = c.decel ? {c.per[13:0], 2'b00} : c.per;
                            if (c.lvl) begin
                                c.lvl     = 1'b0;
                                c.elapsed = c.dir ? c.elapsed - 32'h00000001
                                                  : c.elapsed + 32'h00000001;
                                c.remain  = c.remain - 32'h00000001;
                                if ((c.op == OP_MOVE && c.remain == 32'h00000000)
                                    || (c.op == OP_JOG && c.jten
                                        && c.elapsed == c.tgt)) begin
                                    c.st = ST_IDLE;
                                end
                            end else if (c.op == OP_JOG && !s.cflag[i][2]) begin
                                c.st = ST_IDLE;
                            end else begin
                                c.lvl = 1'b1;
                            end
                        end
                    end
                end
                default: c.st = ST_IDLE;
            endcase
            // rising near-home bit is the trigger
            if (near_c[i] && !s.ch[i].nq && c.op == OP_HOME && c.st != ST_IDLE) begin
                c.decel = 1'b1;
            end
            // forced stop: count may now disagree with the motor
            if (stop_c[i]) begin
                c.st  = ST_IDLE;
                c.lvl = 1'b0;
            end
            // output method
            c.a         = c.meth[1] ? c.lvl : c.lvl & !c.dir;
            c.b         = c.meth[1] ? c.dir ^ c.meth[0] : c.lvl & c.dir;
            c.dc        = c.dcnt != 8'h00;
            next_s.ch[i] = c;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s        <= '0;
            s.ctrl   <= `PTP_CTRL_RST;
            s.mode   <= {2{`PTP_MODE_RST}};
            s.period <= {2{`PTP_PER_RST}};
        end else begin
            s <= next_s;
        end
    end

    assign prdata  = s.prdata;
    assign pready  = s.pready;
    assign pslverr = s.pslverr;

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    property p_ctrl_hold;
        !(wr && paddr == `PTP_CTRL_OFS) |=> s.ctrl == $past(s.ctrl);
    endproperty
    a_ctrl_hold: assert property (p_ctrl_hold)
        else $error("control word changed without a write");

    // one pulse/direction pair per channel
    for (genvar g = 0; g < 2; g++) begin : g_ch
        assign clr_c[g]   = sel_c[g] && s.ctrl[`PTP_CW_CLR];
        assign stop_c[g]  = sel_c[g] && s.ctrl[`PTP_CW_STOP];
        assign near_c[g]  = sel_c[g] && s.ctrl[`PTP_CW_NEAR];
        assign pulse_a[g] = s.ch[g].a;
        assign pulse_b[g] = s.ch[g].b;
        assign dev_clr[g] = s.ch[g].dc;

        property p_cwccw;
            s.ch[g].meth == 2'b00 && s.ch[g].lvl |-> pulse_a[g] != pulse_b[g]
                && pulse_b[g] == s.ch[g].dir;
        endproperty
        a_cwccw: assert property (p_cwccw)
            else $error("cw/ccw pulse on wrong line");

        property p_pol_a;
            s.ch[g].meth == 2'b10 && s.ch[g].st != ST_IDLE |-> pulse_b[g] == s.ch[g].dir;
        endproperty
        a_pol_a: assert property (p_pol_a)
            else $error("direction level wrong in polarity a");

        property p_pol_b;
            s.ch[g].meth == 2'b11 && s.ch[g].st != ST_IDLE |-> pulse_b[g] == !s.ch[g].dir;
        endproperty
        a_pol_b: assert property (p_pol_b)
            else $error("direction level wrong in polarity b");

        property p_move_left;
            s.ch[g].st == ST_RUN && s.ch[g].op == OP_MOVE |-> s.ch[g].remain != 32'h0;
        endproperty
        a_move_left: assert property (p_move_left)
            else $error("move ran past its pulse count");

        property p_count;
            $fell(s.ch[g].lvl) && !$past(stop_c[g]) && !$past(clr_c[g])
                && $past(s.ch[g].op) != OP_HOME
                |-> s.ch[g].elapsed == $past(s.ch[g].elapsed)
                    + ($past(s.ch[g].dir) ? 32'hffffffff : 32'h00000001);
        endproperty
        a_count: assert property (p_count)
            else $error("elapsed count did not follow pulse");

        property p_home;
            s.ch[g].st == ST_RUN && s.ch[g].op == OP_HOME && home_s[g] && !stop_c[g]
                |=> s.ch[g].st == ST_IDLE && s.ch[g].elapsed == 32'h0 && dev_clr[g];
        endproperty
        a_home: assert property (p_home)
            else $error("home return did not finish");

        property p_near;
            near_c[g] && !s.ch[g].nq && s.ch[g].st == ST_RUN && s.ch[g].op == OP_HOME
                && !home_s[g] && !stop_c[g] |=> s.ch[g].decel;
        endproperty
        a_near: assert property (p_near)
            else $error("near-home trigger ignored");

        property p_jog_rel;
            s.ch[g].st == ST_RUN && s.ch[g].op == OP_JOG && !s.cflag[g][2]
                && !s.ch[g].lvl && tick && s.ch[g].cnt <= 16'h0001 |=> s.ch[g].st == ST_IDLE;
        endproperty
        a_jog_rel: assert property (p_jog_rel)
            else $error("jog kept running after release");

        property p_jog_tgt;
            s.ch[g].st == ST_RUN && s.ch[g].op == OP_JOG && s.ch[g].jten
                && !clr_c[g] && !$past(clr_c[g]) |-> s.ch[g].elapsed != s.ch[g].tgt;
        endproperty
        a_jog_tgt: assert property (p_jog_tgt)
            else $error("jog ran at its target");

        property p_stop;
            stop_c[g] |=> s.ch[g].st == ST_IDLE && !pulse_a[g];
        endproperty
        a_stop: assert property (p_stop)
            else $error("forced stop did not halt pulses");

        property p_dir_hold;
            s.ch[g].st != ST_IDLE && $past(s.ch[g].st) != ST_IDLE
                |-> s.ch[g].dir == $past(s.ch[g].dir) && s.ch[g].op == $past(s.ch[g].op);
        endproperty
        a_dir_hold: assert property (p_dir_hold)
            else $error("direction or command changed mid move");
    end

endmodule : ptp_top

// >>> tb/ptp_drv_model.sv
/* motor driver model: counts steps seen on both channels' pins.
   assumes the bench states each channel's output method. */
`timescale 1ns/1ps
module ptp_drv_model (
    // clock
    input  wire logic             pclk,
    // driver pins
    input  wire logic [1:0]       pulse_a,
    input  wire logic [1:0]       pulse_b,
    input  wire logic [1:0][1:0]  meth,
    // motion seen
    output logic      [1:0][31:0] steps,
    output logic      [7:0]       faults
);
    logic [1:0] a_q;
    logic [1:0] b_q;
    initial begin
        steps  = '0;
        faults = '0;
        a_q    = '0;
        b_q    = '0;
    end
    // a real driver latches direction on the pulse edge
    always @(posedge pclk) begin
        for (int c = 0; c < 2; c++) begin
            if (meth[c] == 2'b00) begin
                if (pulse_a[c] && !a_q[c]) steps[c] = steps[c] + 1;
                if (pulse_b[c] && !b_q[c]) steps[c] = steps[c] - 1;
                if (pulse_a[c] && pulse_b[c]) faults = faults + 1;
            end else if (pulse_a[c] && !a_q[c]) begin
                steps[c] = (pulse_b[c] ^ meth[c][0]) ? steps[c] - 1 : steps[c] + 1;
            end
            if (meth[c] != 2'b00 && pulse_a[c] && pulse_b[c] != b_q[c]) faults++;
        end
        a_q = pulse_a;
        b_q = pulse_b;
    end
endmodule : ptp_drv_model

// >>> tb/pulse_train_positioning_output_test.sv
/* bench: apb master, random moves in every mode, stop, home, jog.
   assumes ptp_drv_model on the pins and offsets of ptp_regs.svh. */
`timescale 1ns/1ps
`include "ptp_regs.svh"
module pulse_train_positioning_output_test;
    logic             pclk, presetn, psel, penable, pwrite, pready, pslverr, serr;
    logic [7:0]       paddr, md;
    logic [31:0]      pwdata, prdata, q, t, x, p, m0;
    logic [1:0]       home, pa, pb, dc, nh;
    logic [1:0][1:0]  meth;
    logic [1:0][31:0] steps, pos;
    logic [7:0]       faults;
    logic [15:0]      seed;
    logic [7:0]       modes [6] = '{8'h00, 8'h02, 8'h03, 8'h10, 8'h12, 8'h13};
    int               err_total, compares, k, c;

    ptp_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .home_input_first_channel(home[0]),
        .home_input_second_channel(home[1]), .near_home_source_first(nh[0]),
        .near_home_source_second(nh[1]), .pulse_a(pa), .pulse_b(pb), .dev_clr(dc));
    ptp_drv_model drv_u (.pclk(pclk), .pulse_a(pa), .pulse_b(pb), .meth(meth),
        .steps(steps), .faults(faults));

    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr
    function automatic logic [7:0] ra(input int ch, input logic [4:0] o);
        return (8'h20 << ch) | {3'h0, o};
    endfunction : ra
    // absolute lands on the target, incremental adds it
    function automatic logic [31:0] exp_pos(input logic [7:0] m, input logic [31:0] tg, at);
        return m[4] ? tg : at + tg;
    endfunction : exp_pos

    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : finish_test
    task automatic chk(input string n, input logic [31:0] ex, input logic [31:0] sn);
        compares++;
        if (sn !== ex) begin
            err_total++;
            $display("Error %s expected %h seen %h", n, ex, sn);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int i;
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (i = 0; i < 16; i++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        q = prdata;
        serr = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
        if (i == 16) begin
            chk("pready timeout", 32'h1, 32'h0);
            finish_test();
        end
    endtask : apb
    task automatic rd_pos(input int ch, output logic [31:0] v);
        apb(1'b0, ra(ch, `PTP_ELO_OFS), '0);
        v[15:0] = q[15:0];
        apb(1'b0, ra(ch, `PTP_EHI_OFS), '0);
        v[31:16] = q[15:0];
    endtask : rd_pos
    task automatic wait_idle(input int ch);
        int i;
        for (i = 0; i < 400; i++) begin
            apb(1'b0, ra(ch, `PTP_STAT_OFS), '0);
            if (q[0] === 1'b0) break;
        end
        if (i == 400) begin
            chk("idle timeout", 32'h0, {31'h0, q[0]});
            finish_test();
        end
    endtask : wait_idle

    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata, home, meth, nh} = '0;
        seed = 16'h000d;
        pos = '0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk("pins at reset", 32'h0, {26'h0, pa, pb, dc});
        apb(1'b0, ra(0, `PTP_PER_OFS), '0);
        chk("period reset", 32'h32, q);
        apb(1'b0, 8'h7c, '0);
        chk("unmapped slverr", 32'h1, {31'h0, serr});
        // random moves, every mode code on both channels
        for (k = 0; k < 12; k++) begin
            c = k / 6;
            md = modes[k % 6];
            seed = lfsr(seed);
            t = {29'h0, seed[2:0]} + 32'h1;
            if (seed[3]) t = -t;
            if (md[4]) t = pos[c] + t;
            meth[c] <= md[1:0];
            apb(1'b1, ra(c, `PTP_MODE_OFS), {24'h0, md}); // no counter role here
            apb(1'b1, ra(c, `PTP_TGT_OFS), t);
            apb(1'b1, ra(c, `PTP_PER_OFS), {30'h0, seed[5:4]});
            m0 = steps[c];
            apb(1'b1, ra(c, `PTP_CMD_OFS), 32'h1);
            apb(1'b1, ra(c, `PTP_CMD_OFS), 32'h1);
            wait_idle(c);
            x = exp_pos(md, t, pos[c]);
            rd_pos(c, p);
            chk("elapsed", x, p);
            chk("motor steps", x - pos[c], steps[c] - m0);
            pos[c] = x;
        end
        apb(1'b1, ra(1, `PTP_MODE_OFS), 32'h01);
        apb(1'b1, ra(1, `PTP_CMD_OFS), 32'h1);
        apb(1'b0, ra(1, `PTP_STAT_OFS), '0);
        chk("bad mode busy", 32'h0, {31'h0, q[0]});
        // forced stop on the second channel, then a counter clear
        meth[1] <= 2'b00;
        apb(1'b1, ra(1, `PTP_MODE_OFS), 32'h0);
        apb(1'b1, ra(1, `PTP_TGT_OFS), 32'd1000);
        apb(1'b1, ra(1, `PTP_CMD_OFS), 32'h1);
        repeat (100) @(posedge pclk);
        apb(1'b1, `PTP_CTRL_OFS, 32'h2008);
        apb(1'b1, `PTP_CTRL_OFS, 32'h2000);
        apb(1'b0, ra(1, `PTP_STAT_OFS), '0);
        chk("stopped busy", 32'h0, {31'h0, q[0]});
        m0 = steps[1];
        apb(1'b1, `PTP_CTRL_OFS, 32'h2008);
        apb(1'b1, ra(1, `PTP_CMD_OFS), 32'h1);
        repeat (60) @(posedge pclk);
        chk("held stop", m0, steps[1]);
        apb(1'b1, `PTP_CTRL_OFS, 32'h2001);
        apb(1'b1, `PTP_CTRL_OFS, 32'h2000);
        rd_pos(1, p);
        chk("counter clear", 32'h0, p);
        // home return on the first channel, reverse, with near-home trigger
        meth[0] <= 2'b00;
        apb(1'b1, ra(0, `PTP_MODE_OFS), 32'h0);
        apb(1'b1, ra(0, `PTP_PER_OFS), 32'h1);
        m0 = steps[0];
        apb(1'b1, ra(0, `PTP_CMD_OFS), 32'h12);
        nh[0] <= 1'b1;
        repeat (60) @(posedge pclk);
        apb(1'b1, `PTP_CTRL_OFS, 32'h0010);
        apb(1'b1, `PTP_CTRL_OFS, 32'h0000);
        apb(1'b0, ra(0, `PTP_STAT_OFS), '0);
        chk("decel flag", 32'h1, {31'h0, q[2]});
        chk("near pin", 32'h1, {31'h0, q[4]});
        home[0] <= 1'b1;
        wait_idle(0);
        chk("home pin", 32'h1, {31'h0, q[3]});
        chk("dev clear", 32'h1, {31'h0, dc[0]});
        chk("home ran", 32'h1, {31'h0, $signed(steps[0] - m0) < 0});
        rd_pos(0, p);
        chk("home elapsed", 32'h0, p);
        m0 = steps[0];
        repeat (40) @(posedge pclk);
        chk("home halted", m0, steps[0]);
        home[0] <= 1'b0;
        // jog to a target, then jog held and released
        meth[0] <= 2'b10;
        apb(1'b1, ra(0, `PTP_MODE_OFS), 32'h02);
        apb(1'b1, ra(0, `PTP_TGT_OFS), 32'h3);
        m0 = steps[0];
        apb(1'b1, ra(0, `PTP_CMD_OFS), 32'h123);
        wait_idle(0);
        rd_pos(0, p);
        chk("jog target", 32'h3, p);
        chk("jog steps", 32'h3, steps[0] - m0);
        m0 = steps[0];
        apb(1'b1, ra(0, `PTP_CMD_OFS), 32'h113);
        apb(1'b0, ra(0, `PTP_STAT_OFS), '0);
        chk("jog dir busy", 32'h3, {30'h0, q[1:0]});
        repeat (150) @(posedge pclk);
        apb(1'b1, ra(0, `PTP_CMD_OFS), 32'h0);
        wait_idle(0);
        rd_pos(0, p);
        chk("jog release", p - 32'h3, steps[0] - m0);
        chk("jog reverse", 32'h1, {31'h0, $signed(p) < 3});
        chk("direction faults", 32'h0, {24'h0, faults});
        finish_test();
    end
endmodule : pulse_train_positioning_output_test
